// ==== pkg/sgm_pkg.sv ====
/*
 Shared constants, types and decode helpers of the signal modulator.
 Assumes a 32-bit APB register port with byte addresses.
*/
`default_nettype none
package sgm_pkg;

    // Register map, one aligned word each
    localparam int unsigned SGM_ADDR_W   = 8;
    localparam logic [7:0] SGM_OFS_CTRL  = 8'h00;
    localparam logic [7:0] SGM_OFS_SRC   = 8'h04;
    localparam logic [7:0] SGM_OFS_HIGH_CARRIER  = 8'h08;
    localparam logic [7:0] SGM_OFS_LOW_CARRIER  = 8'h0C;

    // Control register fields and the source register's release bit
    localparam int unsigned SGM_CTRL_EN   = 7;
    localparam int unsigned SGM_CTRL_OE   = 6;
    localparam int unsigned SGM_CTRL_SLEW = 5;
    localparam int unsigned SGM_CTRL_OPOL = 4;
    localparam int unsigned SGM_CTRL_OUT  = 3;
    localparam int unsigned SGM_CTRL_SWB  = 0;
    localparam int unsigned SGM_SRC_DIS   = 7;

    // Reset values and writable bits
    localparam logic [7:0] SGM_CTRL_RST   = 8'h20;
    localparam logic [7:0] SGM_SRC_RST    = 8'h00;
    localparam logic [7:0] SGM_CAR_RST    = 8'h00;
    localparam logic [7:0] SGM_CTRL_WMASK = 8'hF1;
    localparam logic [7:0] SGM_SRC_WMASK  = 8'h8F;
    localparam logic [7:0] SGM_CAR_WMASK  = 8'hEF;

    // Modulator source codes
    localparam logic [3:0] SGM_MOD_SW   = 4'h0;
    localparam logic [3:0] SGM_MOD_PIN  = 4'h1;
    localparam logic [3:0] SGM_MOD_CCP  = 4'h2;
    localparam logic [3:0] SGM_MOD_CMP  = 4'h6;
    localparam logic [3:0] SGM_MOD_SDO  = 4'h8;
    localparam logic [3:0] SGM_MOD_UART = 4'hA;

    // Carrier source codes
    localparam logic [3:0] SGM_CAR_GND  = 4'h0;
    localparam logic [3:0] SGM_CAR_PIN1 = 4'h1;
    localparam logic [3:0] SGM_CAR_PIN2 = 4'h2;
    localparam logic [3:0] SGM_CAR_REF  = 4'h3;
    localparam logic [3:0] SGM_CAR_CCP  = 4'h4;

    // Signals offered by the surrounding peripherals and pins
    typedef struct packed {
        logic [3:0] ccp;
        logic [1:0] cmp;
        logic [1:0] sdo;
        logic       uartTx;
        logic       modInPin;
        logic       carrierPinOne;
        logic       carrierPinTwo;
        logic       refClk;
    } sgm_sources_t;

    // Requests that a peripheral let go of its own output pin
    typedef struct packed {
        logic [3:0] ccp;
        logic [1:0] cmp;
        logic [1:0] sdo;
        logic       uartTx;
    } sgm_release_t;

    // Carrier register layout, bit 4 unused
    typedef struct packed {
        logic       pinDisconnect;
        logic       invert;
        logic       syncEnable;
        logic       unused;
        logic [3:0] select;
    } sgm_car_cfg_t;

    typedef enum logic {SGM_LOW, SGM_HIGH} sgm_car_state_t;

    // One-hot of the compare/PWM unit picked by a code with given base
    function automatic logic [3:0] sgm_ccp_hot(input logic [3:0] code,
                                               input logic [3:0] base);
        logic [3:0] hot;
        hot = 4'h0;
        for (int k = 0; k < 4; k++)
        begin
            if (code == base + 4'(k))
                hot[k] = 1'b1;
        end
        return hot;
    endfunction

endpackage
`default_nettype wire

// ==== src/sgm_carrier_path.sv ====
/*
 One carrier path: source decode, forcing to ground and inversion.
 Assumes sources are synchronous to the clock; purely combinational.
*/
`timescale 1ns/10ps
`default_nettype none
module sgm_carrier_path
    import sgm_pkg::*;
(
    input  wire logic         enable,   // Module enable
    input  wire sgm_car_cfg_t cfg,      // Carrier register
    input  wire sgm_sources_t sources,  // Candidate signals
    output logic              carrier   // Selected, polarity applied
);

    logic raw;

    // Disabled module sees ground whatever is stored in the register
    always_comb
    begin
        raw = 1'b0;
        if (enable)
        begin
            unique case (cfg.select)
                SGM_CAR_GND:         raw = 1'b0;
                SGM_CAR_PIN1:        raw = sources.carrierPinOne;
                SGM_CAR_PIN2:        raw = sources.carrierPinTwo;
                SGM_CAR_REF:         raw = sources.refClk;
                4'h4, 4'h5, 4'h6, 4'h7:
                    raw = sources.ccp[cfg.select[1:0]];
                default:             raw = 1'b0;   // Reserved codes
            endcase
        end
    end

    // Inversion sits ahead of the mixer; a disabled module gives no
    // carrier at all, so an inverted ground cannot leak to the pin
    assign carrier = enable ? (raw ^ cfg.invert) : 1'b0;

endmodule
`default_nettype wire

// ==== src/sgm_modulator.sv ====
/*
 Signal modulator top: APB registers, modulator source select,
 carrier synchronisation, mixing and the modulated pin.
 Assumes all peripheral sources are synchronous to mclk and that
 the APB master follows the usual setup/access sequence.
*/
`timescale 1ns/10ps
`default_nettype none
module sgm_modulator
    import sgm_pkg::*;
(
    input  wire logic                  mclk,       // 125 MHz clock
    input  wire logic                  rst,        // Sync reset, high
    input  wire logic                  psel,       // APB select
    input  wire logic                  penable,    // APB access phase
    input  wire logic                  pwrite,     // APB direction
    input  wire logic [SGM_ADDR_W-1:0] paddr,      // APB byte address
    input  wire logic [31:0]           pwdata,     // APB write data
    output logic      [31:0]           prdata,     // APB read data
    output logic                       pready,     // APB ready
    output logic                       pslverr,    // Unmapped address
    input  wire sgm_sources_t          sources,    // Peripheral signals
    output logic                       modPin,     // Modulated pin
    output logic                       slewLimit,  // Pin slew limiting
    output sgm_release_t               pinRelease  // Pin release requests
);

    // Register contents
    logic [7:0]     ctrl_q;
    logic [7:0]     src_q;
    sgm_car_cfg_t   high_carrier_q;
    sgm_car_cfg_t   low_carrier_q;
    logic           modStatus_q;
    sgm_car_state_t carState_q;
    sgm_car_state_t carState_d;

    // Datapath
    logic           enable;
    logic           highCar;
    logic           lowCar;
    logic [1:0]     carSel;
    logic           modLevel;
    logic           holdHigh;
    logic           holdLow;
    logic           useHigh;
    logic           mixed;
    logic           shaped;
    logic           access;
    logic           commit;
    logic [7:0]     readByte;
    logic           mapped;
    sgm_release_t   release_d;

    // Address decode for the error answer; read and write compare paddr themselves
    function automatic logic isMapped(input logic [SGM_ADDR_W-1:0] a);
        return (a == SGM_OFS_CTRL) || (a == SGM_OFS_SRC) ||
               (a == SGM_OFS_HIGH_CARRIER) || (a == SGM_OFS_LOW_CARRIER);
    endfunction

    assign enable = ctrl_q[SGM_CTRL_EN];

    // ---------------------------------------------------------------
    // APB slave: one wait state, write lands at the edge with pready
    // ---------------------------------------------------------------

    // Access phase seen, answer not yet given
    assign access = psel && penable && !pready;
    // Edge on which the master samples the answer
    assign commit = psel && penable && pready;
    assign mapped = isMapped(paddr);

    // Read mux; status bit is live, unused bits read zero
    always_comb
    begin
        readByte = 8'h00;
        unique case (paddr)
            SGM_OFS_CTRL:
            begin
                readByte = ctrl_q & SGM_CTRL_WMASK;
                readByte[SGM_CTRL_OUT] = modStatus_q;
            end
            SGM_OFS_SRC:  readByte = src_q & SGM_SRC_WMASK;
            SGM_OFS_HIGH_CARRIER: readByte = high_carrier_q & SGM_CAR_WMASK;
            SGM_OFS_LOW_CARRIER: readByte = low_carrier_q & SGM_CAR_WMASK;
            default:      readByte = 8'h00;
        endcase
    end

    // Ready pulses for one cycle, one cycle into the access phase
    always_ff @(posedge mclk)
    begin
        if (rst)
            pready <= 1'b0;
        else
            pready <= access;
    end

    // Read data and error are captured with ready
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (access)
        begin
            prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, readByte};
            pslverr <= !mapped;
        end
        else
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // Control register; clearing enable leaves the others untouched
    always_ff @(posedge mclk)
    begin
        if (rst)
            ctrl_q <= SGM_CTRL_RST;
        else if (commit && pwrite && paddr == SGM_OFS_CTRL)
            ctrl_q <= pwdata[7:0] & SGM_CTRL_WMASK;
    end

    // Selection registers keep their value while disabled
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            src_q  <= SGM_SRC_RST;
            high_carrier_q <= sgm_car_cfg_t'(SGM_CAR_RST);
            low_carrier_q <= sgm_car_cfg_t'(SGM_CAR_RST);
        end
        else if (commit && pwrite)
        begin
            if (paddr == SGM_OFS_SRC)
                src_q <= pwdata[7:0] & SGM_SRC_WMASK;
            if (paddr == SGM_OFS_HIGH_CARRIER)
                high_carrier_q <= sgm_car_cfg_t'(pwdata[7:0] & SGM_CAR_WMASK);
            if (paddr == SGM_OFS_LOW_CARRIER)
                low_carrier_q <= sgm_car_cfg_t'(pwdata[7:0] & SGM_CAR_WMASK);
        end
    end

    // ---------------------------------------------------------------
    // Carrier paths, one per carrier
    // ---------------------------------------------------------------

    for (genvar i = 0; i < 2; i++)
    begin : gCar
        sgm_carrier_path uPath
        (
            .enable  (enable),
            .cfg     ((i == 0) ? high_carrier_q : low_carrier_q),
            .sources (sources),
            .carrier (carSel[i])
        );
    end

    // Index 0 is the high carrier, index 1 the low one; both paths
    // see the same sources, so a switch never waits on routing
    assign highCar = carSel[0];
    assign lowCar  = carSel[1];

    // Modulator source; disabled module listens to the software bit only
    always_comb
    begin
        modLevel = ctrl_q[SGM_CTRL_SWB];
        if (enable)
        begin
            unique case (src_q[3:0])
                SGM_MOD_SW:        modLevel = ctrl_q[SGM_CTRL_SWB];
                SGM_MOD_PIN:       modLevel = sources.modInPin;
                4'h2, 4'h3, 4'h4, 4'h5:
                    modLevel = sources.ccp[2'(src_q[3:0] - SGM_MOD_CCP)];
                4'h6, 4'h7:
                    modLevel = sources.cmp[src_q[0]];
                4'h8, 4'h9:
                    modLevel = sources.sdo[src_q[0]];
                SGM_MOD_UART:      modLevel = sources.uartTx;
                default:           modLevel = 1'b0;   // Nothing connected
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Carrier switching
    // ---------------------------------------------------------------

    // A pending switch waits only while the old carrier is still high
    // and its own sync bit is set, so no pulse is cut short
    assign holdHigh = (carState_q == SGM_HIGH) && !modLevel &&
                      high_carrier_q.syncEnable && highCar;
    assign holdLow  = (carState_q == SGM_LOW) && modLevel &&
                      low_carrier_q.syncEnable && lowCar;

    // Without sync the switch follows the modulator in the same cycle
    assign useHigh = modLevel ? !holdLow : holdHigh;

    assign carState_d = useHigh ? SGM_HIGH : SGM_LOW;

    // Carrier in use is remembered so a held pulse can be finished
    always_ff @(posedge mclk)
    begin
        if (rst)
            carState_q <= SGM_LOW;
        else
            carState_q <= carState_d;
    end

    // Mixer output and output polarity
    assign mixed  = useHigh ? highCar : lowCar;
    assign shaped = mixed ^ ctrl_q[SGM_CTRL_OPOL];

    // Pin is forced low while output is disabled; mixing goes on
    always_ff @(posedge mclk)
    begin
        if (rst)
            modPin <= 1'b0;
        else if (ctrl_q[SGM_CTRL_OE])
            modPin <= shaped;
        else
            modPin <= 1'b0;
    end

    // Status is sampled each clock; faster signals alias here
    always_ff @(posedge mclk)
    begin
        if (rst)
            modStatus_q <= 1'b0;
        else
            modStatus_q <= shaped;
    end

    // Slew control follows its register bit directly
    always_ff @(posedge mclk)
    begin
        if (rst)
            slewLimit <= 1'b1;
        else
            slewLimit <= ctrl_q[SGM_CTRL_SLEW];
    end

    // ---------------------------------------------------------------
    // Pin release toward the source peripherals
    // ---------------------------------------------------------------

    // Only a selected source is released; the signal keeps feeding the mixer
    always_comb
    begin
        release_d = '0;
        if (enable)
        begin
            if (src_q[SGM_SRC_DIS])
            begin
                release_d.ccp = sgm_ccp_hot(src_q[3:0], SGM_MOD_CCP);
                release_d.cmp[0] = (src_q[3:0] == SGM_MOD_CMP);
                release_d.cmp[1] = (src_q[3:0] == SGM_MOD_CMP + 4'h1);
                release_d.sdo[0] = (src_q[3:0] == SGM_MOD_SDO);
                release_d.sdo[1] = (src_q[3:0] == SGM_MOD_SDO + 4'h1);
                release_d.uartTx = (src_q[3:0] == SGM_MOD_UART);
            end
            if (high_carrier_q.pinDisconnect)
                release_d.ccp = release_d.ccp |
                                sgm_ccp_hot(high_carrier_q.select, SGM_CAR_CCP);
            if (low_carrier_q.pinDisconnect)
                release_d.ccp = release_d.ccp |
                                sgm_ccp_hot(low_carrier_q.select, SGM_CAR_CCP);
        end
    end

    // Registered so the request never glitches while decoding settles
    always_ff @(posedge mclk)
    begin
        if (rst)
            pinRelease <= '0;
        else
            pinRelease <= release_d;
    end

endmodule
`default_nettype wire

// ==== tb/sgm_modulator_monitor.sv ====
/* Port checker of the signal modulator, bound below.
   Assumes sync reset rst and a well-formed APB master. */
`timescale 1ns/10ps
`default_nettype none
module sgm_modulator_monitor
    import sgm_pkg::*;
(
    input wire logic                  mclk,       // Clock
    input wire logic                  rst,        // Sync reset
    input wire logic                  psel,       // APB select
    input wire logic                  penable,    // APB access
    input wire logic                  pwrite,     // APB direction
    input wire logic [SGM_ADDR_W-1:0] paddr,      // APB address
    input wire logic [31:0]           pwdata,     // Write data
    input wire logic [31:0]           prdata,     // Read data
    input wire logic                  pready,     // APB ready
    input wire logic                  pslverr,    // APB error
    input wire logic                  modPin,     // Modulated pin
    input wire logic                  slewLimit,  // Slew limit
    input wire sgm_release_t          pinRelease  // Release requests
);
    localparam logic [7:0] WM [4] = '{SGM_CTRL_WMASK, SGM_SRC_WMASK,
                                      SGM_CAR_WMASK, SGM_CAR_WMASK};
    logic [7:0] shReg_q [4];
    logic [7:0] ctrl;
    logic       mapped;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // Word decode; control shadow in view
    assign mapped = (paddr[7:4] == 4'h0) && (paddr[1:0] == 2'h0);
    assign ctrl   = shReg_q[0];

    // Shadow of committed writes, so readback is judged independently
    always_ff @(posedge mclk)
    begin
        if (rst)
            shReg_q <= '{SGM_CTRL_RST, SGM_SRC_RST, SGM_CAR_RST, SGM_CAR_RST};
        else if (psel && penable && pready && pwrite && mapped)
            shReg_q[paddr[3:2]] <= pwdata[7:0] & WM[paddr[3:2]];
    end

    sequence sSetup;
        psel && !penable;
    endsequence
    sequence sAnswer;
        !pready ##1 pready;
    endsequence

    AST_ONE_WAIT: assert property (sSetup |=> sAnswer)
        else $error("ready not one wait state after setup");
    AST_UNMAPPED: assert property (pready |-> pslverr == !mapped)
        else $error("error flag does not match address");
    AST_READBACK: assert property (
        pready && !pwrite && mapped && paddr[3:2] != 2'h0
        |-> prdata == {24'h0, shReg_q[paddr[3:2]]})
        else $error("selection readback differs");
    AST_CTRL_READ: assert property (
        pready && !pwrite && paddr == SGM_OFS_CTRL
        |-> (prdata & 32'hFFFFFFF7) == {24'h0, ctrl})
        else $error("control readback differs");
    AST_OE_LOW: assert property (!ctrl[SGM_CTRL_OE] |=> !modPin)
        else $error("pin high while output disabled");
    AST_OFF_LEVEL: assert property (
        !ctrl[SGM_CTRL_EN] && !$past(ctrl[SGM_CTRL_EN]) && ctrl[SGM_CTRL_OE]
        |=> modPin == $past(ctrl[SGM_CTRL_OPOL]))
        else $error("disabled pin not at polarity level");
    AST_SLEW: assert property (1'b1 |=> slewLimit == $past(ctrl[SGM_CTRL_SLEW]))
        else $error("slew limit does not follow its bit");
    AST_NO_RELEASE: assert property (!ctrl[SGM_CTRL_EN] |=> pinRelease == '0)
        else $error("pin released while disabled");
endmodule

bind sgm_modulator sgm_modulator_monitor sgm_modulator_monitor_i (
    .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .modPin, .slewLimit, .pinRelease
);
`default_nettype wire

// ==== tb/sgm_source_model.sv ====
/* Model of the peripheral signals and pins feeding the modulator.
   Assumes the bench sets requested levels just after clock edges. */
`timescale 1ns/10ps
`default_nettype none
module sgm_source_model
    import sgm_pkg::*;
(
    input  wire logic         mclk,     // Clock
    input  wire logic         rst,      // Sync reset
    input  wire sgm_sources_t levels,   // Requested levels
    input  wire logic         runRef,   // Let the reference clock run
    output sgm_sources_t      sources   // Signals to the modulator
);
    // Registered so every source moves just after an edge
    always_ff @(posedge mclk)
    begin
        if (rst)
            sources <= '0;
        else
        begin
            sources <= levels;
            if (runRef)
                sources.refClk <= !sources.refClk;
        end
    end
endmodule
`default_nettype wire

// ==== tb/test_sgm_modulator.sv ====
/* Self-checking bench of the signal modulator.
   Assumes the source model stands in for all peripherals. */
`timescale 1ns/10ps
`default_nettype none
module test_sgm_modulator
    import sgm_pkg::*;
;
    logic         mclk;
    logic         rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0, prdata, rdat;
    logic         pready, pslverr, modPin, slewLimit, errSeen, last;
    logic         runRef = 1'b0;
    sgm_sources_t lv = '0, sources;
    sgm_release_t pinRelease;
    int           fail_count = 0;
    int           total_checks = 0;

    sgm_source_model sgm_source_model_i (.mclk, .rst, .levels(lv), .runRef, .sources);
    sgm_modulator sgm_modulator_i (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .sources, .modPin, .slewLimit, .pinRelease);

    // Free-running 125 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test;
        $display("Checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // One APB transfer; holds everything until ready is seen
    task automatic apb(input logic isWr, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge mclk);
        psel    <= 1'b1;
        pwrite  <= isWr;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        chk("pready", 32'(pready), 32'h1);
        rd      = prdata;
        errSeen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic put(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d, rdat);
    endtask

    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00, rdat);
        chk(what, rdat, exp);
    endtask

    // Pin needs a source stage and its own register stage to follow
    task automatic pin(input string what, input logic exp);
        repeat (3) @(posedge mclk);
        chk(what, 32'(modPin), 32'(exp));
    endtask

    // Sets the source named by a code to v and all others to its inverse; for modulator codes carrierPinOne stays high
    function automatic sgm_sources_t pick(input logic isCar, input logic [3:0] c,
                                          input logic v);
        sgm_sources_t s;
        s = v ? '0 : '1;
        if (isCar)
        begin
            case (c)
                4'h1: s.carrierPinOne = v;
                4'h2: s.carrierPinTwo = v;
                4'h3: s.refClk = v;
                4'h4, 4'h5, 4'h6, 4'h7: s.ccp[c[1:0]] = v;
                default: ;
            endcase
        end
        else
        begin
            case (c)
                4'h1: s.modInPin = v;
                4'h2, 4'h3, 4'h4, 4'h5: s.ccp[c - 4'h2] = v;
                4'h6, 4'h7: s.cmp[c[0]] = v;
                4'h8, 4'h9: s.sdo[c[0]] = v;
                4'hA: s.uartTx = v;
                default: ;
            endcase
            s.carrierPinOne = 1'b1;
        end
        return s;
    endfunction

    // Main sequence
    initial
    begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        rdc("ctrl reset", SGM_OFS_CTRL, 32'h20);
        rdc("src reset", SGM_OFS_SRC, 32'h00);
        rdc("low_carrier reset", SGM_OFS_LOW_CARRIER, 32'h00);
        chk("slew reset", 32'(slewLimit), 32'h1);
        rdc("unmapped", 8'h10, 32'h0);
        chk("unmapped err", 32'(errSeen), 32'h1);
        put(SGM_OFS_CTRL, 8'hFF);
        rdc("ctrl bits", SGM_OFS_CTRL, 32'hF9);
        put(SGM_OFS_SRC, 8'hFF);
        rdc("src bits", SGM_OFS_SRC, 32'h8F);
        put(SGM_OFS_HIGH_CARRIER, 8'hFF);
        rdc("high_carrier bits", SGM_OFS_HIGH_CARRIER, 32'hEF);
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rdc("high_carrier after reset", SGM_OFS_HIGH_CARRIER, 32'h00);
        chk("pin after reset", 32'(modPin), 32'h0);
        put(SGM_OFS_SRC, 8'h82);
        put(SGM_OFS_HIGH_CARRIER, 8'h86);
        put(SGM_OFS_CTRL, 8'hC0);
        repeat (3) @(posedge mclk);
        chk("release", 32'(pinRelease), 32'h0A0);
        chk("slew cleared", 32'(slewLimit), 32'h0);
        put(SGM_OFS_HIGH_CARRIER, 8'h01);
        for (int m = 0; m < 16; m++)
        begin
            put(SGM_OFS_SRC, 8'(m));
            for (int v = 0; v < 2; v++)
            begin
                lv <= pick(1'b0, 4'(m), v[0]);
                put(SGM_OFS_CTRL, 8'hC0 | 8'(v));
                pin("modulator source", v[0] && m < 11);
            end
        end
        put(SGM_OFS_SRC, 8'h00);
        for (int h = 0; h < 2; h++)
        begin
            put(SGM_OFS_CTRL, 8'hC0 | 8'(h));
            for (int c = 0; c < 16; c++)
            begin
                put(h ? SGM_OFS_HIGH_CARRIER : SGM_OFS_LOW_CARRIER, 8'(c));
                for (int v = 0; v < 2; v++)
                begin
                    lv <= pick(1'b1, 4'(c), v[0]);
                    pin("carrier", v[0] && c > 0 && c < 8);
                end
            end
            put(h ? SGM_OFS_HIGH_CARRIER : SGM_OFS_LOW_CARRIER, 8'h00);
        end
        put(SGM_OFS_HIGH_CARRIER, 8'h03);
        runRef <= 1'b1;
        repeat (4) @(posedge mclk);
        last = modPin;
        @(posedge mclk);
        chk("ref clock", 32'(modPin), 32'(!last));
        runRef <= 1'b0;
        lv <= pick(1'b1, 4'h1, 1'b0);
        put(SGM_OFS_HIGH_CARRIER, 8'h41);
        pin("high inverted", 1'b1);
        put(SGM_OFS_CTRL, 8'hD1);
        pin("output inverted", 1'b0);
        put(SGM_OFS_CTRL, 8'h81);
        pin("pin disabled", 1'b0);
        rdc("status", SGM_OFS_CTRL, 32'h89);
        put(SGM_OFS_CTRL, 8'h41);
        pin("module off", 1'b0);
        rdc("kept select", SGM_OFS_HIGH_CARRIER, 32'h41);
        put(SGM_OFS_CTRL, 8'h51);
        pin("off inverted", 1'b1);
        put(SGM_OFS_CTRL, 8'hC1);
        pin("re-enabled", 1'b1);
        put(SGM_OFS_LOW_CARRIER, 8'h40);
        put(SGM_OFS_CTRL, 8'hC0);
        pin("low inverted", 1'b1);
        lv <= pick(1'b1, 4'h1, 1'b1);
        put(SGM_OFS_LOW_CARRIER, 8'h02);
        put(SGM_OFS_HIGH_CARRIER, 8'h21);
        put(SGM_OFS_CTRL, 8'hC1);
        put(SGM_OFS_CTRL, 8'hC0);
        pin("pulse finishes", 1'b1);
        lv.carrierPinOne <= 1'b0;
        pin("pulse ended", 1'b0);
        lv.carrierPinOne <= 1'b1;
        pin("low carrier now", 1'b0);
        lv.carrierPinTwo <= 1'b1;
        lv.carrierPinOne <= 1'b0;
        put(SGM_OFS_CTRL, 8'hC1);
        pin("leave low at once", 1'b0);
        put(SGM_OFS_LOW_CARRIER, 8'h22);
        put(SGM_OFS_CTRL, 8'hC0);
        put(SGM_OFS_CTRL, 8'hC1);
        pin("low pulse finishes", 1'b1);
        lv.carrierPinTwo <= 1'b0;
        lv.carrierPinOne <= 1'b1;
        pin("high after wait", 1'b1);
        put(SGM_OFS_HIGH_CARRIER, 8'h01);
        put(SGM_OFS_CTRL, 8'hC0);
        pin("no sync switch", 1'b0);
        stop_test();
    end

    // Cuts a hang short; the tests need under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        stop_test();
    end
endmodule
`default_nettype wire
